//--- rtl/scsi_processor_io_rw_decoder.sv
`timescale 1ns/1ps
// Summary of operation
// - bit 6 picks ack, bit 3 attention
// - set instruction sets chosen latch bits
// - clear instruction clears chosen latch bits
// - bit 9 sets or clears target role
// - bit 10 sets or clears carry flag
// - drive ack/atn only as initiator or loopback
// - bit 26 makes alternate address relative
// - bit 25 fetches table at base plus offset
// - table entry: timing, id, sync, zero
// - bits 25/26 give four addressing modes
// - direct mode takes id and address inline
// - bit 24 select-attention, else illegal
// - destination id in bits 18-16
// - opcodes 000-100 I/O, 101-111 register
// - bits 22-16 address one internal register
// - opcode 111 read-modify-write same register
// - 110 into first byte, 101 out of it
// - operator bits 26-24 select alu function
// - shifts rotate through the carry flag
// - transfer opcodes jump, call, return, interrupt
// - transfers conditional on carry, phase, data
// - taken jump or call loads pointer from word 1, bit 23 making it relative
// - call saves pointer, return restores it
module scsi_processor_io_rw_decoder #(
  parameter int REG_AW = 7 // internal register address width
) (
  input wire logic clk, // core clock
  input wire logic rst_b, // async reset, active low
  input wire logic instValid, // one-cycle pulse: instruction words present
  input wire logic [31:0] instWord0, // first instruction word
  input wire logic [31:0] instWord1, // second instruction word
  input wire logic [31:0] instPtr, // current pointer, at next instruction
  input wire logic [31:0] dataStructureBase, // table base address
  input wire logic loopbackEn, // loopback enable of test register two
  input wire logic [2:0] latchedPhase, // phase lines latched on request
  input wire logic atnIn, // attention seen on bus, active high
  input wire logic tableValid, // table word returned
  input wire logic [31:0] tableData, // returned table word
  input wire logic [REG_AW-1:0] peekAddr, // register file read port address
  output logic [7:0] peekData, // register file read data
  output logic busy, // waiting for table word
  output logic tableReq, // table fetch request, held until valid
  output logic [31:0] tableAddr, // table fetch address
  output logic done, // one-cycle pulse: instruction retired
  output logic ipLoad, // one-cycle pulse: take nextIp
  output logic [31:0] nextIp, // new instruction pointer
  output logic [31:0] altAddr, // alternate jump target of I/O
  output logic selStart, // one-cycle pulse: start select/reselect
  output logic selAtn, // attention during selection
  output logic [2:0] destId, // destination scsi id
  output logic [7:0] timingCfg, // loaded timing configuration byte
  output logic [7:0] syncParam, // loaded offset/period byte
  output logic illegalIrq, // one-cycle pulse: illegal instruction
  output logic intReq, // one-cycle pulse: halting interrupt
  output logic intFly, // one-cycle pulse: interrupt on the fly
  output logic [31:0] intVector, // vector of last interrupt
  output logic [1:0] outputLatch, // {ack, atn} of output control latch
  output logic targetMode, // target role bit of control zero
  output logic carry, // alu carry flag
  output logic [7:0] firstByte, // first byte received register
  output logic ackLineOut, // ack pin value, driven low when asserted
  output logic ackLineOe, // ack pin enable
  output logic atnLineOut, // attention pin value
  output logic atnLineOe // attention pin enable
);

  // =====================================================
  // helper functions
  // offsets are 24-bit two's complement, widened to a full word
  function automatic logic [31:0] sext24(input logic [scsi_proc_pkg::OFS_W-1:0] v);
    sext24 = {{(32 - scsi_proc_pkg::OFS_W){v[scsi_proc_pkg::OFS_W-1]}}, v};
  endfunction

  // returns {carryOut, result}; logic ops leave carry alone
  // shifts rotate through carry, so byte and carry form a 9-bit ring
  function automatic logic [8:0] alu(input logic [2:0] op, input logic [7:0] a,
                                     input logic [7:0] imm, input logic cin);
    logic [8:0] r;
    r = {cin, imm};
    case (op)
      scsi_proc_pkg::ALU_LOAD: r = {cin, imm};
      scsi_proc_pkg::ALU_SHL: r = {a[7], a[6:0], cin};
      scsi_proc_pkg::ALU_OR: r = {cin, a | imm};
      scsi_proc_pkg::ALU_XOR: r = {cin, a ^ imm};
      scsi_proc_pkg::ALU_AND: r = {cin, a & imm};
      scsi_proc_pkg::ALU_SHR: r = {a[0], cin, a[7:1]};
      scsi_proc_pkg::ALU_ADD: r = {1'b0, a} + {1'b0, imm};
      default: r = {1'b0, a} + {1'b0, imm} + {8'h00, cin};
    endcase
    alu = r;
  endfunction

  // =====================================================
  // state
  scsi_proc_pkg::exec_state_t state_r, state_nxt;
  logic [7:0] regFile [0:(1<<REG_AW)-1];
  // one temp word only: a second call overwrites the return point
  logic [31:0] temp_r;
  logic [31:0] nextAddr_r; // next address register copy
  logic [31:0] scriptPtrSave_r; // script pointer save copy
  logic [1:0] scsi_output_control_latch_r;
  logic target_r, carry_r;
  logic [7:0] first_byte_received_reg_r;

  // =====================================================
  // field decode
  wire [1:0] instType = instWord0[scsi_proc_pkg::TYPE_HI:scsi_proc_pkg::TYPE_LO];
  wire [2:0] opc = instWord0[scsi_proc_pkg::OPC_HI:scsi_proc_pkg::OPC_LO];
  wire [2:0] opr = instWord0[scsi_proc_pkg::OPR_HI:scsi_proc_pkg::OPR_LO];
  wire isIorw = instValid && (state_r == scsi_proc_pkg::ST_IDLE) &&
                (instType == scsi_proc_pkg::TYPE_IORW);
  wire isXfer = instValid && (state_r == scsi_proc_pkg::ST_IDLE) &&
                (instType == scsi_proc_pkg::TYPE_XFER);
  wire isIo = isIorw && (opc < scsi_proc_pkg::OPC_TO_REG);
  wire isRw = isIorw && (opc >= scsi_proc_pkg::OPC_TO_REG);
  wire isSelFamily = isIo && (opc < scsi_proc_pkg::OPC_SET);
  wire isSelect = isIo && (opc == scsi_proc_pkg::OPC_SELECT) && !target_r;
  wire selAtnBit = instWord0[scsi_proc_pkg::SELATN_BIT];
  wire ioIllegal = isIo && selAtnBit && !isSelect;
  // an illegal set or clear must leave latch, role and carry alone
  wire isSet = isIo && !ioIllegal && (opc == scsi_proc_pkg::OPC_SET);
  wire isClr = isIo && !ioIllegal && (opc == scsi_proc_pkg::OPC_CLEAR);
  wire relMode = instWord0[scsi_proc_pkg::REL_BIT];
  wire tblMode = instWord0[scsi_proc_pkg::TBL_BIT];
  wire [1:0] ackAtnSel = {instWord0[scsi_proc_pkg::ACK_BIT],
                          instWord0[scsi_proc_pkg::ATN_BIT]};

  // alternate target and table address for the select family
  wire [31:0] relTarget = instPtr + sext24(instWord1[scsi_proc_pkg::OFS_W-1:0]);
  wire [31:0] altTarget = relMode ? relTarget : instWord1;
  wire [31:0] tblAddrCalc = dataStructureBase +
                            sext24(instWord0[scsi_proc_pkg::OFS_W-1:0]);
  wire needTable = isSelFamily && !ioIllegal && tblMode;

  // register read/write datapath
  wire [REG_AW-1:0] regAddr = instWord0[scsi_proc_pkg::RA_LO +: REG_AW];
  wire [7:0] immByte = instWord0[scsi_proc_pkg::IMM_HI:scsi_proc_pkg::IMM_LO];
  wire [7:0] regRead = regFile[regAddr];
  wire [7:0] aluSrc = (opc == scsi_proc_pkg::OPC_TO_REG) ? first_byte_received_reg_r : regRead;
  wire [8:0] aluOut = alu(opr, aluSrc, immByte, carry_r);
  wire writeReg = isRw && (opc != scsi_proc_pkg::OPC_TO_FBR);
  wire writeFbr = isRw && (opc == scsi_proc_pkg::OPC_TO_FBR);

  // =====================================================
  // transfer control condition
  wire [2:0] wantPhase = instWord0[scsi_proc_pkg::OPR_HI:scsi_proc_pkg::OPR_LO];
  wire cTest = instWord0[scsi_proc_pkg::TC_CTEST_BIT];
  wire cData = instWord0[scsi_proc_pkg::TC_CDATA_BIT];
  wire cPhase = instWord0[scsi_proc_pkg::TC_CPHASE_BIT];
  wire onTrue = instWord0[scsi_proc_pkg::TC_TRUE_BIT];
  wire [7:0] dMask = instWord0[scsi_proc_pkg::MASK_HI:scsi_proc_pkg::MASK_LO];
  wire [7:0] dVal = instWord0[scsi_proc_pkg::VAL_HI:scsi_proc_pkg::VAL_LO];
  // in target role the phase compare becomes an attention test
  wire phaseOk = target_r ? atnIn : (latchedPhase == wantPhase);
  wire dataOk = ((first_byte_received_reg_r ^ dVal) & ~dMask) == 8'h00;
  wire allTrue = (!cPhase || phaseOk) && (!cData || dataOk);
  wire allFalse = (!cPhase || !phaseOk) && (!cData || !dataOk);
  // with no compare chosen both chains read true: jump-if-false is taken
  wire condTaken = cTest ? (carry_r == onTrue) :
                   (onTrue ? allTrue : allFalse);
  wire xferTaken = isXfer && condTaken;
  wire xferIllegal = isXfer && opc[2];
  wire [31:0] xferTarget = instWord0[scsi_proc_pkg::TC_REL_BIT] ?
                           instPtr + sext24(instWord1[scsi_proc_pkg::OFS_W-1:0]) :
                           instWord1;
  wire doJump = xferTaken && !xferIllegal &&
                (opc == scsi_proc_pkg::OPC_JUMP || opc == scsi_proc_pkg::OPC_CALL);
  wire doCall = xferTaken && (opc == scsi_proc_pkg::OPC_CALL);
  wire doRet = xferTaken && (opc == scsi_proc_pkg::OPC_RETURN);
  wire doInt = xferTaken && (opc == scsi_proc_pkg::OPC_INTR);
  wire doFly = doInt && instWord0[scsi_proc_pkg::TC_FLY_BIT];

  // =====================================================
  // sequencing: only table fetches stall
  // limitation: a table fetch cannot be cancelled; new instructions wait
  wire tableDone = (state_r == scsi_proc_pkg::ST_TABLE) && tableValid;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      scsi_proc_pkg::ST_IDLE: if (needTable) state_nxt = scsi_proc_pkg::ST_TABLE;
      scsi_proc_pkg::ST_TABLE: if (tableValid) state_nxt = scsi_proc_pkg::ST_IDLE;
      default: state_nxt = scsi_proc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= scsi_proc_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign busy = (state_r == scsi_proc_pkg::ST_TABLE);
  assign tableReq = busy;

  // =====================================================
  // set/clear of latch, role and carry; set wins nothing here since
  // only one instruction is ever in flight
  logic [1:0] soclNxt;
  logic targetNxt, carryNxt;
  always_comb begin
    soclNxt = scsi_output_control_latch_r;
    targetNxt = target_r;
    carryNxt = carry_r;
    if (isSet) begin
      soclNxt = scsi_output_control_latch_r | ackAtnSel;
      if (instWord0[scsi_proc_pkg::TARGET_BIT]) targetNxt = 1'b1;
      if (instWord0[scsi_proc_pkg::CARRY_BIT]) carryNxt = 1'b1;
    end else if (isClr) begin
      soclNxt = scsi_output_control_latch_r & ~ackAtnSel;
      if (instWord0[scsi_proc_pkg::TARGET_BIT]) targetNxt = 1'b0;
      if (instWord0[scsi_proc_pkg::CARRY_BIT]) carryNxt = 1'b0;
    end else if (isRw) begin
      carryNxt = aluOut[8];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scsi_output_control_latch_r <= 2'b00;
      target_r <= 1'b0;
      carry_r <= 1'b0;
    end else begin
      scsi_output_control_latch_r <= soclNxt;
      target_r <= targetNxt;
      carry_r <= carryNxt;
    end
  end

  // =====================================================
  // register file and first byte register; the array has no reset so
  // it maps onto plain storage
  // limitation: a peek in the write cycle still shows the old byte
  always_ff @(posedge clk) begin
    if (writeReg) regFile[regAddr] <= aluOut[7:0];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first_byte_received_reg_r <= scsi_proc_pkg::BYTE_RST;
    end else if (writeFbr) begin
      first_byte_received_reg_r <= aluOut[7:0];
    end
  end

  always_ff @(posedge clk) begin
    peekData <= regFile[peekAddr];
  end

  // =====================================================
  // select family: id, attention, alternate address, table load
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nextAddr_r <= scsi_proc_pkg::WORD_RST;
      altAddr <= scsi_proc_pkg::WORD_RST;
      destId <= 3'h0;
      selAtn <= 1'b0;
      tableAddr <= scsi_proc_pkg::WORD_RST;
    end else if (isSelFamily && !ioIllegal) begin
      nextAddr_r <= instWord1;
      altAddr <= altTarget;
      // bits 23-19 are not part of the id; only the table offset reads them
      destId <= instWord0[scsi_proc_pkg::ID_HI:scsi_proc_pkg::ID_LO];
      selAtn <= isSelect && selAtnBit;
      tableAddr <= tblAddrCalc;
    end else if (tableDone) begin
      // only three id bits are live in the table byte
      destId <= tableData[scsi_proc_pkg::TE_ID_LO +: scsi_proc_pkg::TE_ID_W];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timingCfg <= scsi_proc_pkg::BYTE_RST;
      syncParam <= scsi_proc_pkg::BYTE_RST;
    end else if (tableDone) begin
      timingCfg <= tableData[scsi_proc_pkg::TE_TIMING_LO +: 8];
      syncParam <= tableData[scsi_proc_pkg::TE_SYNC_LO +: 8];
    end
  end

  // =====================================================
  // transfer control: pointer, temp and interrupts
  // return ignores bit 23 and always goes back to the temp word
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scriptPtrSave_r <= scsi_proc_pkg::WORD_RST;
      temp_r <= scsi_proc_pkg::WORD_RST;
      nextIp <= scsi_proc_pkg::WORD_RST;
      intVector <= scsi_proc_pkg::WORD_RST;
    end else begin
      if (isXfer) scriptPtrSave_r <= instWord1;
      if (doCall) temp_r <= instPtr;
      if (doJump) nextIp <= xferTarget;
      else if (doRet) nextIp <= temp_r;
      if (doInt) intVector <= instWord1;
    end
  end

  // retire and select-start strobes, kept as named wires
  wire retireNow = (instValid && !busy && !needTable) || tableDone;
  wire selGo = (isSelFamily && !ioIllegal && !tblMode) || tableDone;
  // illegal covers bit 24 off a select and transfer opcodes 1xx
  // intReq halts the sequencer, intFly lets it run on
  // one-cycle event pulses
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ipLoad <= 1'b0;
      done <= 1'b0;
      selStart <= 1'b0;
      illegalIrq <= 1'b0;
      intReq <= 1'b0;
      intFly <= 1'b0;
    end else begin
      ipLoad <= doJump || doRet;
      done <= retireNow;
      selStart <= selGo;
      illegalIrq <= ioIllegal || xferIllegal;
      intReq <= doInt && !doFly;
      intFly <= doFly;
    end
  end

  // =====================================================
  // pins: active-low lines pulled low only while allowed to drive
  wire driveOk = !target_r || loopbackEn;
  // the pin value is a fixed low; the enable alone pulls the line
  assign ackLineOut = 1'b0;
  assign atnLineOut = 1'b0;
  assign ackLineOe = scsi_output_control_latch_r[1] && driveOk;
  assign atnLineOe = (scsi_output_control_latch_r[0] || (selAtn && busy)) && driveOk;

  assign outputLatch = scsi_output_control_latch_r;
  assign targetMode = target_r;
  assign carry = carry_r;
  assign firstByte = first_byte_received_reg_r;

endmodule

//--- shared/scsi_proc_pkg.sv
package scsi_proc_pkg;
  // =====================================================
  // instruction field positions
  localparam int TYPE_HI = 31;
  localparam int TYPE_LO = 30;
  localparam int OPC_HI = 29;
  localparam int OPC_LO = 27;
  localparam int OPR_HI = 26;
  localparam int OPR_LO = 24;
  localparam int REL_BIT = 26;
  localparam int TBL_BIT = 25;
  localparam int SELATN_BIT = 24;
  localparam int ID_HI = 18;
  localparam int ID_LO = 16;
  localparam int CARRY_BIT = 10;
  localparam int TARGET_BIT = 9;
  localparam int ACK_BIT = 6;
  localparam int ATN_BIT = 3;
  localparam int RA_HI = 22;
  localparam int RA_LO = 16;
  localparam int IMM_HI = 15;
  localparam int IMM_LO = 8;
  localparam int TC_REL_BIT = 23;
  localparam int TC_CTEST_BIT = 21;
  localparam int TC_FLY_BIT = 20;
  localparam int TC_TRUE_BIT = 19;
  localparam int TC_CDATA_BIT = 18;
  localparam int TC_CPHASE_BIT = 17;
  localparam int MASK_HI = 15;
  localparam int MASK_LO = 8;
  localparam int VAL_HI = 7;
  localparam int VAL_LO = 0;
  localparam int OFS_W = 24;

  // =====================================================
  // instruction classes and opcodes
  localparam logic [1:0] TYPE_IORW = 2'h1;
  localparam logic [1:0] TYPE_XFER = 2'h2;
  localparam logic [2:0] OPC_SELECT = 3'h0;
  localparam logic [2:0] OPC_SET = 3'h3;
  localparam logic [2:0] OPC_CLEAR = 3'h4;
  localparam logic [2:0] OPC_TO_REG = 3'h5;
  localparam logic [2:0] OPC_TO_FBR = 3'h6;
  localparam logic [2:0] OPC_RMW = 3'h7;
  localparam logic [2:0] OPC_JUMP = 3'h0;
  localparam logic [2:0] OPC_CALL = 3'h1;
  localparam logic [2:0] OPC_RETURN = 3'h2;
  localparam logic [2:0] OPC_INTR = 3'h3;

  // alu operators
  localparam logic [2:0] ALU_LOAD = 3'h0;
  localparam logic [2:0] ALU_SHL = 3'h1;
  localparam logic [2:0] ALU_OR = 3'h2;
  localparam logic [2:0] ALU_XOR = 3'h3;
  localparam logic [2:0] ALU_AND = 3'h4;
  localparam logic [2:0] ALU_SHR = 3'h5;
  localparam logic [2:0] ALU_ADD = 3'h6;
  localparam logic [2:0] ALU_ADC = 3'h7;

  // table entry byte lanes, lowest address first
  localparam int TE_TIMING_LO = 0;
  localparam int TE_ID_LO = 8;
  localparam int TE_SYNC_LO = 16;
  localparam int TE_ID_W = 3;

  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  typedef enum logic [0:0] {ST_IDLE, ST_TABLE} exec_state_t;
endpackage

//--- tb/scsi_decoder_properties.sv
`timescale 1ns/1ps
// ==========
// port checks for the script decoder
module scsi_decoder_checker (
  input wire logic clk, // core clock
  input wire logic rst_b, // reset, active low
  input wire logic instValid, // instruction strobe
  input wire logic [31:0] instWord0, // word 0
  input wire logic [31:0] instWord1, // word 1
  input wire logic [31:0] dataStructureBase, // table base
  input wire logic loopbackEn, // loopback
  input wire logic tableValid, // table beat
  input wire logic [31:0] tableData, // table word
  input wire logic busy, // fetch wait
  input wire logic [31:0] tableAddr, // fetch address
  input wire logic done, // retired
  input wire logic [31:0] altAddr, // alternate target
  input wire logic selStart, // select start
  input wire logic [2:0] destId, // target id
  input wire logic [7:0] timingCfg, // timing byte
  input wire logic [7:0] syncParam, // sync byte
  input wire logic illegalIrq, // illegal pulse
  input wire logic [1:0] outputLatch, // ack, atn
  input wire logic targetMode, // role
  input wire logic carry, // alu carry
  input wire logic ackLineOe // ack enable
);
  // decode of the instruction taken at this edge
  wire take = instValid && !busy;
  wire io = take && instWord0[31:30] == scsi_proc_pkg::TYPE_IORW;
  wire [2:0] opc = instWord0[29:27];
  wire isSet = opc == scsi_proc_pkg::OPC_SET;
  wire setClr = io && !instWord0[24] && (isSet || opc == scsi_proc_pkg::OPC_CLEAR);
  wire sel = io && opc == scsi_proc_pkg::OPC_SELECT;
  wire [31:0] tblAddr = dataStructureBase + {{8{instWord0[23]}}, instWord0[23:0]};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_tbl_take; sel && instWord0[25] && !(instWord0[24] && targetMode); endsequence
  sequence s_tbl_back; busy && tableValid; endsequence
  // ==========
  // properties
  property p_set_ack; setClr && isSet && instWord0[6] |=> outputLatch[1] && done; endproperty
  a_set_ack: assert property (p_set_ack) else $error("ack latch not set");
  property p_target; setClr && instWord0[9] |=> targetMode == $past(isSet); endproperty
  a_target: assert property (p_target) else $error("role bit wrong");
  property p_carry; setClr && instWord0[10] |=> carry == $past(isSet); endproperty
  a_carry: assert property (p_carry) else $error("carry bit wrong");
  property p_ack_pin; ackLineOe == (outputLatch[1] && (!targetMode || loopbackEn)); endproperty
  a_ack_pin: assert property (p_ack_pin) else $error("ack drive wrong");
  property p_direct; sel && instWord0[26:24] == 3'h0 |=> selStart
    && destId == $past(instWord0[18:16]) && altAddr == $past(instWord1); endproperty
  a_direct: assert property (p_direct) else $error("direct select wrong");
  property p_fetch; s_tbl_take |=> busy && tableAddr == $past(tblAddr); endproperty
  a_fetch: assert property (p_fetch) else $error("table address wrong");
  property p_fill; s_tbl_back |=> done && selStart && !busy && timingCfg == $past(tableData[7:0])
    && syncParam == $past(tableData[23:16]) && destId == $past(tableData[10:8]); endproperty
  a_fill: assert property (p_fill) else $error("table entry load wrong");
  property p_illegal; io && opc != 3'h0 && opc < 3'h5 && instWord0[24]
    |=> illegalIrq && outputLatch == $past(outputLatch); endproperty
  a_illegal: assert property (p_illegal) else $error("illegal attention bit missed");
endmodule

bind scsi_processor_io_rw_decoder scsi_decoder_checker chk_u (.clk, .rst_b, .instValid,
  .instWord0, .instWord1, .dataStructureBase, .loopbackEn, .tableValid, .tableData, .busy,
  .tableAddr, .done, .altAddr, .selStart, .destId, .timingCfg, .syncParam, .illegalIrq,
  .outputLatch, .targetMode, .carry, .ackLineOe);

//--- tb/scsi_processor_io_rw_decoder_tb_top.sv
`timescale 1ns/1ps
// ==========
// bench: instruction sequences with worked-out results
module scsi_processor_io_rw_decoder_tb_top;
  logic clk, tableValid, cy, busy, tableReq, done, ipLoad, selStart, selAtn, illegalIrq;
  logic intReq, intFly, targetMode, carry, ackLineOut, ackLineOe, atnLineOut, atnLineOe;
  logic rst_b = 1'b0, instValid = 1'b0, loopbackEn = 1'b0, atnIn = 1'b0;
  logic [31:0] instWord0 = 32'h0, instWord1 = 32'h0, instPtr = 32'h0000_1000;
  logic [31:0] dataStructureBase = 32'h0002_0000; // longword aligned
  logic [31:0] tableData, tableAddr, nextIp, altAddr, intVector;
  logic [7:0] peekData, timingCfg, syncParam, firstByte, rv, fb, lag = 8'h00;
  logic [6:0] peekAddr = 7'h00;
  logic [2:0] latchedPhase = 3'h3, destId;
  logic [1:0] outputLatch;
  logic [31:0] iow [8] = '{32'h5800_0048, 32'h5800_0200, 32'h5800_0000, 32'h6000_0208,
    32'h6000_0040, 32'h5900_0040, 32'h5800_0400, 32'h6000_0400};
  logic [7:0] ioe [8] = '{8'h0f, 8'h1c, 8'h9f, 8'h0a, 8'h00, 8'h40, 8'h20, 8'h00};
  logic [7:0] imms [8] = '{8'ha5, 8'h00, 8'h0c, 8'hff, 8'h3c, 8'h00, 8'hf0, 8'h20};
  logic [31:0] sw0 [3] = '{32'h40fd_0000, 32'h4403_0000, 32'h4106_0000};
  logic [31:0] sw1 [3] = '{32'h0000_4000, 32'h00ff_fff0, 32'h0000_2000};
  logic [39:0] sex [3] = '{40'h15_0000_4000, 40'h13_0000_0ff0, 40'h1e_0000_2000};
  logic [31:0] tw0 [11] = '{32'h8028_0000, 32'h8020_0000, 32'h830a_0000, 32'h820a_0000,
    32'h800c_00c0, 32'h800c_00c1, 32'h8800_0000, 32'h9000_0000, 32'h9800_0000,
    32'h9810_0000, 32'ha000_0000};
  logic [31:0] tw1 [11] = '{32'h5000, 32'h5000, 32'h5000, 32'h5000, 32'h5000, 32'h5000,
    32'h3000, 32'h0, 32'hcafe_0001, 32'hcafe_0001, 32'h0};
  logic [3:0] te [11] = '{4'h0, 4'h1, 4'h1, 4'h0, 4'h1, 4'h0, 4'h1, 4'h1, 4'h2, 4'h8, 4'h4};
  int errors, checks_done;
  wire [8:0] ioSt = {ackLineOut, atnLineOut, illegalIrq, carry, targetMode, outputLatch,
    ackLineOe, atnLineOe};

  scsi_processor_io_rw_decoder dut_u (.clk, .rst_b, .instValid, .instWord0, .instWord1,
    .instPtr, .dataStructureBase, .loopbackEn, .latchedPhase, .atnIn, .tableValid, .tableData,
    .peekAddr, .peekData, .busy, .tableReq, .tableAddr, .done, .ipLoad, .nextIp, .altAddr,
    .selStart, .selAtn, .destId, .timingCfg, .syncParam, .illegalIrq, .intReq, .intFly,
    .intVector, .outputLatch, .targetMode, .carry, .firstByte, .ackLineOut, .ackLineOe,
    .atnLineOut, .atnLineOe);
  scsi_table_mem_model mem_u (.clk, .rst_b, .tableReq, .tableAddr, .lagCycles(lag),
    .tableValid, .tableData);

  // ==========
  // clock, and a guard far beyond the hundred or so cycles the tests need
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    errors++;
    results();
  end
  // verdict and end of run
  task automatic results();
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // compare; four-state so an unknown never matches
  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  // one instruction held over one edge; pulses are visible on return
  task automatic exec(input logic [31:0] w0, input logic [31:0] w1);
    @(negedge clk);
    instValid = 1'b1;
    instWord0 = w0;
    instWord1 = w1;
    @(negedge clk);
    instValid = 1'b0;
  endtask
  // read port answers one cycle after the address
  task automatic peek(input logic [6:0] a);
    @(negedge clk);
    peekAddr = a;
    @(negedge clk);
  endtask
  // table select: offsets stay well inside 8 MB of the base
  task automatic tsel(input logic [31:0] w0, input logic [7:0] lg);
    logic [31:0] ta;
    int n;
    ta = dataStructureBase + {{8{w0[23]}}, w0[23:0]};
    lag = lg;
    exec(w0, 32'h0000_0100);
    chk("tableAddr", {2'b11, ta}, {busy, tableReq, tableAddr});
    n = 0;
    while (done !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk("entry", {1'b1, ta[7:0] ^ 8'h5a, ta[7:0] ^ 8'hc3, ta[6:4]},
      {selStart, timingCfg, syncParam, destId});
  endtask

  // ==========
  // main sequence
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    chk("resetState", 7'h00, ioSt);
    // set and clear steps, loopback on for one of them
    for (int i = 0; i < 8; i++) begin
      loopbackEn = ioe[i][7];
      exec(iow[i], 32'h0);
      chk("ioState", ioe[i][6:0], ioSt);
    end
    // all eight operators on one register, carry tracked alongside
    cy = 1'b0;
    for (int i = 0; i < 8; i++) begin
      exec({2'b01, 3'h7, i[2:0], 1'b0, 7'h11, imms[i], 8'h00}, 32'h0);
      case (i)
        0: rv = imms[i];
        1: {cy, rv} = {rv, cy};
        2: rv = rv | imms[i];
        3: rv = rv ^ imms[i];
        4: rv = rv & imms[i];
        5: {rv, cy} = {cy, rv};
        6: {cy, rv} = rv + imms[i];
        default: {cy, rv} = rv + imms[i] + cy;
      endcase
      peek(7'h11);
      chk("rmw", {cy, rv}, {carry, peekData});
    end
    // into the first-byte register and back out of it
    exec({2'b01, 3'h6, 3'h6, 1'b0, 7'h11, 8'h17, 8'h00}, 32'h0);
    {cy, fb} = rv + 8'h17;
    chk("toFirstByte", {cy, fb}, {carry, firstByte});
    exec({2'b01, 3'h5, 3'h2, 1'b0, 7'h22, 8'h05, 8'h00}, 32'h0);
    peek(7'h22);
    chk("fromFirstByte", fb | 8'h05, peekData);
    // direct, relative and attention selects, reserved bits set in the first
    for (int i = 0; i < 3; i++) begin
      exec(sw0[i], sw1[i]);
      chk("select", sex[i], {selStart, selAtn, destId, altAddr});
    end
    tsel(32'h4200_0040, 8'h03);
    tsel(32'h46ff_fff0, 8'h00);
    chk("tableRelAlt", instPtr + 32'h100, altAddr);
    // conditional jumps, then call, return and interrupt
    for (int i = 0; i < 11; i++) begin
      exec(tw0[i], tw1[i]);
      chk("xferPulse", {1'b1, te[i]}, {done, intFly, illegalIrq, intReq, ipLoad});
      if (te[i][0])
        chk("nextIp", tw0[i][29:27] == 3'h2 ? instPtr : tw1[i], nextIp);
    end
    chk("intVector", tw1[8], intVector);
    results();
  end
endmodule

//--- tb/scsi_table_mem_model.sv
`timescale 1ns/1ps
// ==========
// host memory holding table entries, answers after a set lag
module scsi_table_mem_model (
  input wire logic clk, // core clock
  input wire logic rst_b, // reset, active low
  input wire logic tableReq, // fetch request
  input wire logic [31:0] tableAddr, // fetch address
  input wire logic [7:0] lagCycles, // answer delay in cycles
  output logic tableValid, // one-beat answer
  output logic [31:0] tableData // entry word
);
  logic [7:0] waitCnt_r;
  // lanes from low byte: timing, id, offset/period, zero
  wire [31:0] entry = {8'h00, tableAddr[7:0] ^ 8'hc3, 5'h00, tableAddr[6:4],
    tableAddr[7:0] ^ 8'h5a};
  // released data flips so a stale word never passes for fresh
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt_r <= 8'h00;
      tableValid <= 1'b0;
      tableData <= 32'hffff_ffff;
    end else begin
      tableValid <= 1'b0;
      if (tableValid) begin
        tableData <= ~tableData;
      end else if (tableReq && waitCnt_r == lagCycles) begin
        tableValid <= 1'b1;
        tableData <= entry;
        waitCnt_r <= 8'h00;
      end else if (tableReq) begin
        waitCnt_r <= waitCnt_r + 8'h01;
      end
    end
  end
endmodule
